// [dae_fifo.sv]
`timescale 1ns/1ps
`include "dae_map.svh"
module dae_fifo #(
    parameter int unsigned WIDTH = `DAE_FIFO_WIDTH,
    parameter int unsigned DEPTH = `DAE_FIFO_DEPTH
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import dae_pkg::*;
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] cnt;
    logic [AW:0] next_cnt;
    logic push;
    logic pop;

    // Handshakes and next fill level
    always_comb
    begin
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    assign out_data = mem[rptr];

    // Storage
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wptr] <= in_data;
    end

    // Pointers, level and registered flags
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
                wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
            if (pop)
                rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
            cnt <= next_cnt;
            in_ready <= next_cnt != (AW+1)'(DEPTH);
            out_valid <= next_cnt != '0;
        end
    end
endmodule : dae_fifo

// [dae_i2c_dev.sv]
`timescale 1ns/1ps
`include "dae_map.svh"
// Function
// - Start begins a new address phase
// - Stop ends the transaction
// - Repeated start detected like normal start
// - SDA moves with SCL low, sampled rising
// - Device drives bits after falling SCL
// - Eight bits MSB first, ninth acknowledges
// - Master sends byte, samples slave acknowledge
// - Master acks more, nacks final byte
// - First byte is address plus direction
// - Answer auxiliary and programmable main address
// - Mismatch ignores bus until next start
// - Equal addresses: only main memory answers
// - Second write byte loads address counter
// - Page writes wrap within 8-byte row
// - Busy after page write, no acknowledge
// - Master polls or waits write time
// - Whole page rewritten, unwritten bytes kept
// - Shadow select writes skip nonvolatile cycle
// - Reads start at current address counter
// - Dummy write then repeated start reads
// - Reads increment freely, roll FFh to 00h
// - SDA only pulled low or released
module dae_i2c_dev #(
    parameter int unsigned NVW_CYC = `DAE_NVW_CYC
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    dae_if.dev bus,
    input wire logic shadow_sel,
    output logic busy,
    output dae_pkg::dae_byte_t last_addr
);
    import dae_pkg::*;
    localparam int unsigned CW = $clog2(NVW_CYC + 1);
    localparam logic [7:0] AUX = `DAE_AUX_ADDR;
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    dae_dev_st_t st;
    logic [7:0] sh;
    logic [7:0] txd;
    logic [7:0] addr_cnt;
    logic [3:0] bitcnt;
    logic [1:0] byte_idx;
    logic sel_main;
    logic rw;
    logic m_ack;
    logic sda_oe;
    logic pg_dirty;
    logic [CW-1:0] busy_cnt;
    logic [7:0] mem_aux [`DAE_MEM_WORDS];
    logic [7:0] mem_main [`DAE_MEM_WORDS];
    logic [7:0] main_adr;
    logic hit_main;
    logic hit_aux;
    logic byte_end;
    logic wr_en;
    logic [7:0] rd_byte;

    // Two-stage synchronisers plus one delay stage for edges
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_s1 <= bus.scl;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    // Bus events and address decode
    always_comb
    begin
        rise = scl_s2 & ~scl_d;
        fall = ~scl_s2 & scl_d;
        start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
        stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;
        main_adr = mem_main[`DAE_MAIN_EN_LOC][`DAE_MAIN_EN_BIT] ? mem_main[`DAE_MAIN_ADDR_LOC]
                                                                : `DAE_MAIN_ADDR_DEF;
        hit_main = sh[7:1] == main_adr[7:1];
        hit_aux = (sh[7:1] == AUX[7:1]) & ~hit_main;
        byte_end = (st == DEV_RX) & fall & (bitcnt == 4'h8);
        wr_en = byte_end & (byte_idx == 2'h2);
        rd_byte = sel_main ? mem_main[addr_cnt] : mem_aux[addr_cnt];
    end

    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe = sda_oe;

    // Protocol state machine
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= DEV_IDLE;
            sh <= 8'h00;
            txd <= 8'h00;
            addr_cnt <= 8'h00;
            bitcnt <= 4'h0;
            byte_idx <= 2'h0;
            sel_main <= 1'b0;
            rw <= 1'b0;
            m_ack <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (start_c)
        begin
            st <= DEV_RX;
            bitcnt <= 4'h0;
            byte_idx <= 2'h0;
            sda_oe <= 1'b0;
        end
        else if (stop_c)
        begin
            st <= DEV_IDLE;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (st)
                DEV_RX:
                begin
                    if (rise)
                    begin
                        sh <= {sh[6:0], sda_s2};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    else if (byte_end)
                    begin
                        if (byte_idx == 2'h0)
                        begin
                            if (!busy && (hit_main || hit_aux))
                            begin
                                sel_main <= hit_main;
                                rw <= sh[0];
                                sda_oe <= 1'b1;
                                st <= DEV_RX_ACK;
                                byte_idx <= 2'h1;
                            end
                            else
                                st <= DEV_IDLE;
                        end
                        else
                        begin
                            sda_oe <= 1'b1;
                            st <= DEV_RX_ACK;
                            byte_idx <= 2'h2;
                            if (byte_idx == 2'h1)
                                addr_cnt <= sh;
                            else
                                addr_cnt <= {addr_cnt[7:3], addr_cnt[2:0] + 3'h1};
                        end
                    end
                end
                DEV_RX_ACK:
                begin
                    if (fall)
                    begin
                        bitcnt <= 4'h0;
                        // first read bit after falling edge
                        if (rw)
                        begin
                            txd <= rd_byte;
                            sda_oe <= ~rd_byte[7];
                            addr_cnt <= addr_cnt + 8'h01;
                            st <= DEV_TX;
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            st <= DEV_RX;
                        end
                    end
                end
                DEV_TX:
                begin
                    if (rise)
                        bitcnt <= bitcnt + 4'h1;
                    else if (fall)
                    begin
                        if (bitcnt == 4'h8)
                        begin
                            sda_oe <= 1'b0;
                            st <= DEV_TX_ACK;
                        end
                        else
                        begin
                            txd <= {txd[6:0], 1'b0};
                            sda_oe <= ~txd[6];
                        end
                    end
                end
                DEV_TX_ACK:
                begin
                    if (rise)
                        m_ack <= ~sda_s2;
                    else if (fall)
                    begin
                        bitcnt <= 4'h0;
                        if (m_ack)
                        begin
                            txd <= rd_byte;
                            sda_oe <= ~rd_byte[7];
                            addr_cnt <= addr_cnt + 8'h01;
                            st <= DEV_TX;
                        end
                        else
                            st <= DEV_IDLE;
                    end
                end
                default:
                    st <= DEV_IDLE;
            endcase
        end
    end

    // Memory arrays; untouched bytes of a page keep their value
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < `DAE_MEM_WORDS; i++)
            begin
                mem_aux[i] <= `DAE_MEM_RST;
                mem_main[i] <= `DAE_MEM_RST;
            end
        end
        else if (wr_en)
        begin
            if (sel_main)
                mem_main[addr_cnt] <= sh;
            else
                mem_aux[addr_cnt] <= sh;
        end
    end

    // Pending nonvolatile page write and last written address
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pg_dirty <= 1'b0;
            last_addr <= 8'h00;
        end
        else
        begin
            if (wr_en)
                last_addr <= addr_cnt;
            if (wr_en && !shadow_sel)
                pg_dirty <= 1'b1;
            else if (stop_c || start_c)
                pg_dirty <= pg_dirty & stop_c & 1'b0;
        end
    end

    // Write-time counter started by the stop
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy <= 1'b0;
            busy_cnt <= '0;
        end
        else if (stop_c && pg_dirty)
        begin
            busy <= 1'b1;
            busy_cnt <= CW'(NVW_CYC - 1);
        end
        else if (busy)
        begin
            if (busy_cnt == '0)
                busy <= 1'b0;
            else
                busy_cnt <= busy_cnt - CW'(1);
        end
    end
endmodule : dae_i2c_dev

// [dae_i2c_host.sv]
`timescale 1ns/1ps
`include "dae_map.svh"
module dae_i2c_host #(
    parameter int unsigned QTR = `DAE_SCL_QTR,
    parameter int unsigned FIFO_DEPTH = `DAE_FIFO_DEPTH
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    dae_if.host bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_rd,
    input wire logic req_set,
    input wire dae_pkg::dae_byte_t req_dev,
    input wire dae_pkg::dae_byte_t req_mem,
    input wire logic [3:0] req_len,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire dae_pkg::dae_byte_t wr_data,
    output logic rd_valid,
    output dae_pkg::dae_byte_t rd_data,
    output logic done,
    output logic nack
);
    import dae_pkg::*;
    dae_host_st_t st;
    dae_phase_t ph;
    logic [15:0] div;
    logic [1:0] q;
    logic [3:0] bitcnt;
    logic [3:0] left;
    logic [8:0] sh;
    logic [8:0] rx;
    logic r_rd;
    logic [7:0] r_dev;
    logic [7:0] r_mem;
    logic sda_s1;
    logic sda_s2;
    logic scl;
    logic oe;
    logic run;
    logic tick;
    logic end_op;
    logic f_valid;
    logic f_pop;
    logic [7:0] f_data;

    dae_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_data),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );

    // Quarter-period timing of the generated clock
    always_comb
    begin
        run = (st != HOST_IDLE) && (st != HOST_WAIT);
        tick = run && (div == 16'(QTR - 1));
        end_op = tick && (q == 2'h3);
        f_pop = (st == HOST_WAIT) && f_valid;
    end

    assign bus.scl = scl;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe = oe;

    // Divider and quarter index
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div <= 16'h0000;
            q <= 2'h0;
        end
        else if (!run)
        begin
            div <= 16'h0000;
            q <= 2'h0;
        end
        else
        begin
            div <= tick ? 16'h0000 : div + 16'h0001;
            if (tick)
                q <= q + 2'h1;
        end
    end

    // Bus pins per quarter; data SDA moves while SCL is low, start and stop in the high quarter
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl <= 1'b1;
            oe <= 1'b0;
        end
        else if (tick)
        begin
            case (q)
                2'h0:
                    oe <= (st == HOST_BIT) ? ~sh[8] : (st == HOST_STOP);
                2'h1:
                    scl <= 1'b1;
                2'h2:
                begin
                    if (st == HOST_START)
                        oe <= 1'b1;
                    if (st == HOST_STOP)
                        oe <= 1'b0;
                end
                default:
                    if (st != HOST_STOP)
                        scl <= 1'b0;
            endcase
        end
    end

    // Synchronise SDA and sample it in the high phase
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            rx <= 9'h000;
        end
        else
        begin
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
            // acknowledge read like a data bit
            if (tick && q == 2'h2 && st == HOST_BIT)
                rx <= {rx[7:0], sda_s2};
        end
    end

    // Transfer sequencer
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= HOST_IDLE;
            ph <= PH_ADDR;
            bitcnt <= 4'h0;
            left <= 4'h0;
            sh <= 9'h1ff;
            r_rd <= 1'b0;
            r_dev <= 8'h00;
            r_mem <= 8'h00;
            req_ready <= 1'b1;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
            done <= 1'b0;
            nack <= 1'b0;
        end
        else
        begin
            rd_valid <= 1'b0;
            done <= 1'b0;
            case (st)
                HOST_IDLE:
                    if (req_valid)
                    begin
                        r_rd <= req_rd;
                        r_dev <= req_dev;
                        r_mem <= req_mem;
                        left <= req_len;
                        nack <= 1'b0;
                        req_ready <= 1'b0;
                        ph <= (req_rd && !req_set) ? PH_RADDR : PH_ADDR;
                        st <= HOST_START;
                    end
                HOST_START:
                    if (end_op)
                    begin
                        sh <= {r_dev[7:1], ph == PH_RADDR, 1'b1};
                        bitcnt <= 4'h0;
                        st <= HOST_BIT;
                    end
                HOST_WAIT:
                    if (f_valid)
                    begin
                        sh <= {f_data, 1'b1};
                        bitcnt <= 4'h0;
                        st <= HOST_BIT;
                    end
                HOST_BIT:
                    if (end_op && bitcnt != 4'h8)
                    begin
                        sh <= {sh[7:0], 1'b1};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    else if (end_op)
                    begin
                        bitcnt <= 4'h0;
                        if (ph == PH_RDATA)
                        begin
                            rd_valid <= 1'b1;
                            rd_data <= rx[8:1];
                            left <= left - 4'h1;
                            // ack unless next byte is last
                            sh <= {8'hff, left == 4'h2};
                            if (left == 4'h1)
                                st <= HOST_STOP;
                        end
                        else if (rx[0])
                        begin
                            nack <= 1'b1;
                            st <= HOST_STOP;
                        end
                        else if (ph == PH_ADDR)
                        begin
                            ph <= PH_MADDR;
                            sh <= {r_mem, 1'b1};
                        end
                        else if (ph == PH_RADDR)
                        begin
                            ph <= PH_RDATA;
                            sh <= {8'hff, left == 4'h1};
                        end
                        else if (ph == PH_MADDR && r_rd)
                        begin
                            ph <= PH_RADDR;
                            st <= HOST_START;
                        end
                        else if (ph == PH_MADDR)
                        begin
                            ph <= PH_WDATA;
                            st <= (left == 4'h0) ? HOST_STOP : HOST_WAIT;
                        end
                        else
                        begin
                            left <= left - 4'h1;
                            st <= (left == 4'h1) ? HOST_STOP : HOST_WAIT;
                        end
                    end
                HOST_STOP:
                    if (end_op)
                    begin
                        done <= 1'b1;
                        req_ready <= 1'b1;
                        st <= HOST_IDLE;
                    end
                default:
                    st <= HOST_IDLE;
            endcase
        end
    end
endmodule : dae_i2c_host

// [dae_if.sv]
`timescale 1ns/1ps
interface dae_if;
    logic scl;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic sda;
    // Wired-and bus with pull-up
    assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
    modport dev (
        input scl,
        input sda,
        output s_sda_o,
        output s_sda_oe
    );
    modport host (
        output scl,
        output m_sda_o,
        output m_sda_oe,
        input sda
    );
endinterface : dae_if

// [dae_map.svh]
`ifndef DAE_MAP_SVH
`define DAE_MAP_SVH
`define DAE_AUX_ADDR 8'ha0
`define DAE_MAIN_ADDR_DEF 8'ha2
`define DAE_MAIN_ADDR_LOC 8'h8c
`define DAE_MAIN_EN_LOC 8'h8b
`define DAE_MAIN_EN_BIT 0
`define DAE_MEM_RST 8'h00
`define DAE_MEM_WORDS 256
`define DAE_CLK_NS 10
`define DAE_NVW_TIME_NS 10000000
`define DAE_NVW_CYC (`DAE_NVW_TIME_NS / `DAE_CLK_NS)
`define DAE_SCL_QTR 25
`define DAE_FIFO_DEPTH 16
`define DAE_FIFO_WIDTH 8
`endif

// [dae_pkg.sv]
package dae_pkg;
    typedef logic [7:0] dae_byte_t;
    // Device bus-side states
    typedef enum logic [2:0] {
        DEV_IDLE = 3'b000,
        DEV_RX = 3'b001,
        DEV_RX_ACK = 3'b010,
        DEV_TX = 3'b011,
        DEV_TX_ACK = 3'b100
    } dae_dev_st_t;
    // Master bit-engine operations
    typedef enum logic [2:0] {
        HOST_IDLE = 3'b000,
        HOST_START = 3'b001,
        HOST_BIT = 3'b010,
        HOST_WAIT = 3'b011,
        HOST_STOP = 3'b100
    } dae_host_st_t;
    // Master transfer phases
    typedef enum logic [2:0] {
        PH_ADDR = 3'b000,
        PH_MADDR = 3'b001,
        PH_WDATA = 3'b010,
        PH_RADDR = 3'b011,
        PH_RDATA = 3'b100
    } dae_phase_t;
endpackage : dae_pkg

// [dae_sva.sv]
`timescale 1ns/1ps
module dae_sva (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    input wire logic sda
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // Open-drain drive on both ends and the pulled-up wire
    property p_dev_low; s_sda_oe |-> !s_sda_o; endproperty
    a_dev_low: assert property (p_dev_low) else $error("device drives sda high");
    property p_host_low; m_sda_oe |-> !m_sda_o; endproperty
    a_host_low: assert property (p_host_low) else $error("host drives sda high");
    property p_wire; sda == !(m_sda_oe || s_sda_oe); endproperty
    a_wire: assert property (p_wire) else $error("sda level wrong");
    // Device moves sda only inside the low phase of scl
    property p_dev_move; $changed(s_sda_oe) |-> !scl && !$past(scl); endproperty
    a_dev_move: assert property (p_dev_move) else $error("device sda moved with scl high");
    // Clock phases hold for at least eight cycles after each edge
    property p_scl_hi; $rose(scl) |=> scl [*8]; endproperty
    a_scl_hi: assert property (p_scl_hi) else $error("scl high too short");
    property p_scl_lo; $fell(scl) |=> !scl [*8]; endproperty
    a_scl_lo: assert property (p_scl_lo) else $error("scl low too short");
    // Device lets go of sda within a byte
    property p_release; $rose(s_sda_oe) |-> ##[1:1000] !s_sda_oe; endproperty
    a_release: assert property (p_release) else $error("device holds sda");
    // Only one end drives while scl is high
    property p_no_clash; scl |-> !(s_sda_oe && m_sda_oe); endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive sda");
    // Sda moves under a high scl only for a start or stop from the host
    property p_start_stop; scl && $past(scl) && $changed(sda) |-> $changed(m_sda_oe) && !s_sda_oe; endproperty
    a_start_stop: assert property (p_start_stop) else $error("sda moved with scl high");
endmodule : dae_sva

// [dual_address_eeprom_i2c_slave_tb.sv]
`timescale 1ns/1ps
module dual_address_eeprom_i2c_slave_tb;
    import dae_pkg::*;
    logic core_clk = 0, rst_b = 0, shadow_sel = 0, req_valid = 0, req_rd = 0, req_set = 0, wr_valid = 0;
    logic busy, req_ready, wr_ready, rd_valid, done, nack;
    logic [3:0] req_len = 4'h0;
    dae_byte_t req_dev = 8'h00, req_mem = 8'h00, wr_data = 8'h00, last_addr, rd_data, la = 8'h00;
    dae_byte_t mm[2][256];
    dae_byte_t cnt[2];
    dae_byte_t q[$];
    dae_byte_t d[$];
    int fail_count = 0, n_tests = 0, i;
    time t0;
    dae_if dae_if_i ();
    dae_i2c_dev #(.NVW_CYC(2000)) dae_i2c_dev_i (.core_clk(core_clk), .rst_b(rst_b), .bus(dae_if_i),
        .shadow_sel(shadow_sel), .busy(busy), .last_addr(last_addr));
    dae_i2c_host #(.QTR(8)) dae_i2c_host_i (.core_clk(core_clk), .rst_b(rst_b), .bus(dae_if_i),
        .req_valid(req_valid), .req_ready(req_ready), .req_rd(req_rd), .req_set(req_set), .req_dev(req_dev),
        .req_mem(req_mem), .req_len(req_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
    dae_sva dae_sva_i (.core_clk(core_clk), .rst_b(rst_b), .scl(dae_if_i.scl), .m_sda_o(dae_if_i.m_sda_o),
        .m_sda_oe(dae_if_i.m_sda_oe), .s_sda_o(dae_if_i.s_sda_o), .s_sda_oe(dae_if_i.s_sda_oe), .sda(dae_if_i.sda));
    // Core clock
    initial
        forever #5 core_clk = ~core_clk;
    task finish_test;
        $display("tests %0d errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Ends the run when a bounded wait runs out
    task guard(input logic ok);
        if (!ok)
        begin
            fail_count++;
            finish_test;
        end
    endtask : guard
    // Streams bytes into the write buffer, valid held throughout
    task push(input dae_byte_t b[$]);
        wr_valid = 1;
        foreach (b[j])
        begin
            wr_data = b[j];
            q.push_back(b[j]);
            @(negedge core_clk);
        end
        wr_valid = 0;
    endtask : push
    // One transaction, checked against the memory model
    task xfer(input logic rd, input logic st, input dae_byte_t dv, input dae_byte_t ma, input int n, input logic en);
        int k;
        int s;
        int r;
        dae_byte_t a;
        dae_byte_t m;
        // Main address as programmed in the model; any other address picks aux
        m = mm[0][8'h8b][0] ? mm[0][8'h8c] : 8'ha2;
        s = (dv[7:1] == m[7:1]) ? 0 : 1;
        r = 0;
        chk("req_ready", {7'h00, req_ready}, 8'h01);
        req_rd = rd;
        req_set = st;
        req_dev = dv;
        req_mem = ma;
        req_len = n[3:0];
        req_valid = 1;
        @(negedge core_clk);
        req_valid = 0;
        chk("req_ready", {7'h00, req_ready}, 8'h00);
        a = ma;
        for (k = 0; k < n && !rd && !en; k++)
        begin
            mm[s][a] = q.pop_front();
            la = a;
            a = {a[7:3], a[2:0] + 3'h1};
            cnt[s] = a;
        end
        if (rd && st && !en)
            cnt[s] = ma;
        for (k = 0; k < 40000 && done !== 1'b1; k++)
        begin
            @(negedge core_clk);
            if (rd_valid === 1'b1)
            begin
                chk("rd_data", rd_data, mm[s][cnt[s]]);
                cnt[s]++;
                r++;
            end
        end
        guard(k < 40000);
        chk("rd_count", 8'(r), (rd && !en) ? 8'(n) : 8'h00);
        chk("nack", {7'h00, nack}, {7'h00, en});
        chk("last_addr", last_addr, la);
    endtask : xfer
    // Main sequence
    initial
    begin
        void'($urandom(32'h6fa0));
        mm = '{default: 8'h00};
        cnt = '{default: 8'h00};
        repeat (4) @(negedge core_clk);
        rst_b = 1;
        repeat (3) @(negedge core_clk);
        for (i = 0; i < 16; i++)
            d.push_back(dae_byte_t'($urandom));
        push(d);
        @(negedge core_clk);
        chk("wr_ready", {7'h00, wr_ready}, 8'h00);
        xfer(0, 0, 8'ha2, 8'h3d, 8, 0);
        chk("busy", {7'h00, busy}, 8'h01);
        t0 = $time;
        xfer(1, 1, 8'ha2, 8'h00, 1, 1);
        for (i = 0; i < 3000 && busy !== 1'b0; i++)
            @(negedge core_clk);
        guard(busy === 1'b0);
        // Busy lasts the write time counted from the stop
        chk("busy_len", {7'h00, ($time - t0) / 10 > 1990 && ($time - t0) / 10 <= 2000}, 8'h01);
        xfer(1, 1, 8'ha2, 8'h3c, 6, 0);
        shadow_sel = 1;
        xfer(0, 0, 8'ha0, 8'hfe, 8, 0);
        chk("busy", {7'h00, busy}, 8'h00);
        xfer(1, 1, 8'ha0, 8'hf9, 8, 0);
        xfer(1, 0, 8'ha0, 8'h00, 2, 0);
        xfer(0, 0, 8'h50, 8'h00, 0, 1);
        d = '{8'h01, 8'h60};
        push(d);
        xfer(0, 0, 8'ha2, 8'h8b, 2, 0);
        xfer(1, 1, 8'ha2, 8'h3d, 1, 1);
        xfer(1, 1, 8'h60, 8'h3d, 1, 0);
        // Main address moved onto the aux address: only main answers
        d = '{8'ha0};
        push(d);
        xfer(0, 0, 8'h60, 8'h8c, 1, 0);
        xfer(1, 1, 8'ha0, 8'h3d, 1, 0);
        finish_test;
    end
endmodule : dual_address_eeprom_i2c_slave_tb
